// ---- rtl/rad_pkg.sv ----
/*
 * Constants and types for the reset address decoder: default processor
 * map windows, target codes, limits on programmed windows.
 * Assumes a 32-bit processor address and one system clock.
 */
package rad_pkg;

    localparam int AW = 32;
    localparam int DEF_N = 4;
    localparam int PROG_N = 4;
    localparam int WIN_N = DEF_N + PROG_N;
    localparam int IDX_W = 2;
    localparam int TGT_N = 8;

    // Decode targets; index into the chip select vector
    typedef enum logic [2:0] {
        RAD_TGT_NONE = 3'h0,
        RAD_TGT_PCI_IO = 3'h1,
        RAD_TGT_MEM_CTRL = 3'h2,
        RAD_TGT_HOST_BRIDGE = 3'h3,
        RAD_TGT_FLASH_A = 3'h4,
        RAD_TGT_FLASH_B = 3'h5,
        RAD_TGT_PCI_MEM = 3'h6,
        RAD_TGT_DRAM = 3'h7
    } rad_tgt_t;

    // Which map drives the decode
    typedef enum logic {
        RAD_MAP_DEFAULT = 1'b0,
        RAD_MAP_PROG = 1'b1
    } rad_map_t;

    // Default map windows, inclusive bounds, slot order is priority order
    localparam logic [AW-1:0] DEF_LO [DEF_N] = '{
        32'h8000_0000, 32'hfef8_0000, 32'hfeff_0000, 32'hfff0_0000};
    localparam logic [AW-1:0] DEF_HI [DEF_N] = '{
        32'h8080_ffff, 32'hfef8_ffff, 32'hfeff_ffff, 32'hffff_ffff};
    localparam int DEF_SLOT_BOOT = 3;

    // Limits on programmed windows
    localparam logic [AW-1:0] FLASH_MAX_SPAN = 32'h00ff_ffff;
    localparam logic [AW-1:0] RAM_MAX_HI = 32'h7fff_ffff;
    localparam logic [AW-1:0] PCI_MEM_ALIGN = 32'h0fff_ffff;

    localparam logic [TGT_N-1:0] CS_ONE = 8'h01;
    localparam logic [TGT_N-1:0] CS_NONE = 8'h00;

endpackage : rad_pkg

// ---- rtl/rad_win_if.sv ----
/*
 * Carrier between the decoder top and one window comparator.
 * Assumes both ends sit in the system clock domain; purely combinational.
 */
`timescale 1ns/100ps
interface rad_win_if;
    logic [31:0] addr;
    logic [31:0] lo;
    logic [31:0] hi;
    logic [31:0] ofs;
    logic hit;

    modport win (input addr, input lo, input hi, output hit, output ofs);
    modport user (output addr, output lo, output hi, input hit, input ofs);
endinterface : rad_win_if

// ---- rtl/rad_window_match.sv ----
/*
 * One address window comparator: inclusive bounds, window-relative offset.
 * Assumes lo <= hi; the owner checks that before a window is enabled.
 */
`timescale 1ns/100ps
module rad_window_match (
    rad_win_if.win w // Window compare port
);

    // Inclusive range test and zero-based offset inside the window
    assign w.hit = (w.addr >= w.lo) && (w.addr <= w.hi);
    assign w.ofs = w.addr - w.lo;

endmodule : rad_window_match

// ---- rtl/rad_top.sv ----
/*
 * Processor-side address decoder of a host bridge and memory controller.
 * Applies the fixed default map after reset and a programmed window table
 * once software commits it. Assumes requests are synchronous to sys_clk
 * and that the programming strobes come from local configuration logic.
 */
// Summary of operation
// - Reset always loads the fixed default map; it stays until software commits a programmed map.
// - Default map follows the standard platform region layout.
// - Default decodes stay unchanged; only software commit replaces them.
// - Programmed flash windows at most 16MB; RAM windows below 2GB.
// - 8000_0000..8080_FFFF goes to zero-based PCI/ISA I/O window.
// - 64KB at FEF8_0000 selects the memory controller registers.
// - 64KB at FEFF_0000 selects the host bridge registers.
// - Top 1MB boots from flash A, or bank B when swap select set.
// - Addresses are 32-bit; dual address cycles are never generated.
// - PCI slave decoders are off after reset until software enables them.
`timescale 1ns/100ps
module rad_top (
    input wire logic sys_clk, // System clock, 125 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire logic req_valid, // Processor access request
    input wire logic [rad_pkg::AW-1:0] req_addr, // Processor address
    input wire logic req_write, // Access is a write
    input wire logic boot_bank_swap_select, // Boot window to bank B
    input wire logic map_wr_en, // Write one programmed window
    input wire logic [rad_pkg::IDX_W-1:0] map_wr_idx, // Window slot
    input wire logic [rad_pkg::AW-1:0] map_wr_lo, // Window low bound
    input wire logic [rad_pkg::AW-1:0] map_wr_hi, // Window high bound
    input wire rad_pkg::rad_tgt_t map_wr_tgt, // Window target
    input wire logic map_wr_enable, // Window enable
    input wire logic map_commit, // Switch to programmed map
    input wire logic map_revert, // Return to default map
    input wire logic pci_slave_dec_wr, // Write PCI slave decode enable
    input wire logic pci_slave_dec_on, // New PCI slave decode enable
    output logic rsp_valid_ff, // Decode result valid, one cycle
    output rad_pkg::rad_tgt_t rsp_tgt_ff, // Decoded target
    output logic [rad_pkg::TGT_N-1:0] rsp_cs_ff, // One-hot chip selects
    output logic [rad_pkg::AW-1:0] rsp_ofs_ff, // Window-relative offset
    output logic rsp_write_ff, // Write flag of the access
    output logic rsp_miss_ff, // Access hit no window
    output logic map_prog_mode_ff, // Programmed map active
    output logic map_wr_err_ff, // Window write refused
    output logic pci_slave_dec_en_ff, // PCI slave decoders enabled
    output logic pci_dac_ff // Dual address cycle request
);
    import rad_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Reset release

    logic rst_meta_ff;
    logic rst_sync_ff;

    // Two-stage release so the deassertion is clean
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Map mode state

    rad_map_t map_mode_ff;
    rad_map_t nxt_map_mode;

    // Only an explicit commit leaves the default map
    always_comb begin
        nxt_map_mode = map_mode_ff;
        unique case (map_mode_ff)
            RAD_MAP_DEFAULT: if (map_commit) nxt_map_mode = RAD_MAP_PROG;
            RAD_MAP_PROG: if (map_revert) nxt_map_mode = RAD_MAP_DEFAULT;
        endcase
    end

    // Reset forces the default map back in
    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            map_mode_ff <= RAD_MAP_DEFAULT;
        end else begin
            map_mode_ff <= nxt_map_mode;
        end
    end

    wire prog_active = (map_mode_ff == RAD_MAP_PROG);

    ////////////////////////////////////////////////////////////////////////
    // Programmed window table

    logic [AW-1:0] prog_lo_ff [PROG_N];
    logic [AW-1:0] prog_hi_ff [PROG_N];
    rad_tgt_t prog_tgt_ff [PROG_N];
    logic [PROG_N-1:0] prog_en_ff;

    // Window legality; a refused write leaves the slot untouched
    wire [AW-1:0] wr_span = map_wr_hi - map_wr_lo;
    wire wr_is_flash = (map_wr_tgt == RAD_TGT_FLASH_A) || (map_wr_tgt == RAD_TGT_FLASH_B);
    wire wr_order_ok = map_wr_lo <= map_wr_hi;
    wire wr_flash_ok = !wr_is_flash || (wr_span <= FLASH_MAX_SPAN);
    wire wr_ram_ok = (map_wr_tgt != RAD_TGT_DRAM) || (map_wr_hi <= RAM_MAX_HI);
    wire wr_legal = wr_order_ok && wr_flash_ok && wr_ram_ok;
    wire wr_take = map_wr_en && wr_legal;

    // Table storage; disabled after reset so only the default map decodes
    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            for (int k = 0; k < PROG_N; k++) begin
                prog_lo_ff[k] <= '0;
                prog_hi_ff[k] <= '0;
                prog_tgt_ff[k] <= RAD_TGT_NONE;
            end
            prog_en_ff <= '0;
        end else if (wr_take) begin
            prog_lo_ff[map_wr_idx] <= map_wr_lo;
            prog_hi_ff[map_wr_idx] <= map_wr_hi;
            prog_tgt_ff[map_wr_idx] <= map_wr_tgt;
            prog_en_ff[map_wr_idx] <= map_wr_enable;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Window compare

    rad_win_if win [WIN_N] ();
    logic [WIN_N-1:0] win_ok;
    rad_tgt_t win_tgt [WIN_N];
    logic [AW-1:0] win_ofs [WIN_N];

    // Boot window bank follows the swap select level
    wire rad_tgt_t boot_tgt = boot_bank_swap_select ? RAD_TGT_FLASH_B : RAD_TGT_FLASH_A;

    // Default slots first, programmed slots after; each slot gated by mode
    for (genvar i = 0; i < WIN_N; i++) begin : g_win
        assign win[i].addr = req_addr;
        if (i < DEF_N) begin : g_def
            assign win[i].lo = DEF_LO[i];
            assign win[i].hi = DEF_HI[i];
            assign win_ok[i] = win[i].hit && !prog_active;
            if (i == DEF_SLOT_BOOT) begin : g_boot
                assign win_tgt[i] = boot_tgt;
            end else begin : g_reg
                assign win_tgt[i] = rad_tgt_t'(i + 1);
            end
        end else begin : g_prog
            assign win[i].lo = prog_lo_ff[i-DEF_N];
            assign win[i].hi = prog_hi_ff[i-DEF_N];
            assign win_ok[i] = win[i].hit && prog_active && prog_en_ff[i-DEF_N];
            assign win_tgt[i] = prog_tgt_ff[i-DEF_N];
        end
        assign win_ofs[i] = win[i].ofs;
        rad_window_match u_match (
            .w(win[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority select; lowest slot wins on overlap

    logic sel_hit;
    rad_tgt_t sel_tgt;
    logic [AW-1:0] sel_ofs;

    // Gaps fall through with no target
    always_comb begin
        sel_hit = 1'b0;
        sel_tgt = RAD_TGT_NONE;
        sel_ofs = '0;
        for (int k = WIN_N - 1; k >= 0; k--) begin
            if (win_ok[k]) begin
                sel_hit = 1'b1;
                sel_tgt = win_tgt[k];
                sel_ofs = win_ofs[k];
            end
        end
    end

    wire take_hit = req_valid && sel_hit;
    wire [TGT_N-1:0] nxt_rsp_cs = take_hit ? (CS_ONE << sel_tgt) : CS_NONE;

    ////////////////////////////////////////////////////////////////////////
    // Response stage; one cycle after the request

    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            rsp_valid_ff <= 1'b0;
            rsp_tgt_ff <= RAD_TGT_NONE;
            rsp_cs_ff <= CS_NONE;
            rsp_ofs_ff <= '0;
            rsp_write_ff <= 1'b0;
            rsp_miss_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= req_valid;
            rsp_tgt_ff <= take_hit ? sel_tgt : RAD_TGT_NONE;
            rsp_cs_ff <= nxt_rsp_cs;
            rsp_ofs_ff <= take_hit ? sel_ofs : '0;
            rsp_write_ff <= req_valid && req_write;
            rsp_miss_ff <= req_valid && !sel_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags

    // Decode enable for PCI slave side; off until software turns it on
    always_ff @(posedge sys_clk or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            pci_slave_dec_en_ff <= 1'b0;
            map_wr_err_ff <= 1'b0;
            map_prog_mode_ff <= 1'b0;
            pci_dac_ff <= 1'b0;
        end else begin
            if (pci_slave_dec_wr) pci_slave_dec_en_ff <= pci_slave_dec_on;
            map_wr_err_ff <= map_wr_en && !wr_legal;
            map_prog_mode_ff <= (nxt_map_mode == RAD_MAP_PROG);
            pci_dac_ff <= 1'b0; // addresses never exceed 32 bits
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_sync_ff);

    wire def_req = req_valid && !prog_active;

    AST_PCI_IO: assert property (def_req && req_addr >= DEF_LO[0] && req_addr <= DEF_HI[0]
        |=> rsp_cs_ff[RAD_TGT_PCI_IO] && rsp_ofs_ff == $past(req_addr) - DEF_LO[0])
        else $error("PCI I/O window not decoded");
    AST_MEM_CTRL: assert property (def_req && req_addr[31:16] == DEF_LO[1][31:16]
        |=> rsp_tgt_ff == RAD_TGT_MEM_CTRL && rsp_ofs_ff[31:16] == 16'h0000)
        else $error("Memory controller window not decoded");
    AST_HOST_BRIDGE: assert property (def_req && req_addr[31:16] == DEF_LO[2][31:16]
        |=> rsp_cs_ff == (CS_ONE << RAD_TGT_HOST_BRIDGE))
        else $error("Host bridge window not decoded");
    AST_BOOT_BANK: assert property (def_req && req_addr >= DEF_LO[3]
        |=> rsp_tgt_ff == ($past(boot_bank_swap_select) ? RAD_TGT_FLASH_B
                                                          : RAD_TGT_FLASH_A))
        else $error("Boot window bank wrong");
    AST_LOW_GAP: assert property (def_req && req_addr < DEF_LO[0]
        |=> rsp_miss_ff && rsp_cs_ff == CS_NONE)
        else $error("Unmapped low space selected a target");
    AST_MISS_NO_CS: assert property (rsp_miss_ff |-> rsp_cs_ff == CS_NONE
        && rsp_tgt_ff == RAD_TGT_NONE && rsp_valid_ff)
        else $error("Miss with a chip select");
    AST_PROG_ONLY_BY_COMMIT: assert property ($rose(map_prog_mode_ff)
        |-> $past(map_commit) && $past(map_mode_ff) == RAD_MAP_DEFAULT)
        else $error("Programmed map without commit");
    AST_DEFAULT_HOLDS: assert property (!prog_active && !map_commit
        |=> !prog_active [*2] or map_commit [*1] ##0 1'b1 or ##1 map_commit)
        else $error("Default map left without commit");
    AST_FLASH_LIMIT: assert property (map_wr_en && wr_is_flash && wr_span > FLASH_MAX_SPAN
        |=> map_wr_err_ff && $stable(prog_en_ff))
        else $error("Oversize flash window accepted");
    AST_PCI_SLAVE: assert property ($rose(pci_slave_dec_en_ff)
        |-> $past(pci_slave_dec_wr && pci_slave_dec_on))
        else $error("PCI slave decode enabled without write");
    AST_NO_DAC: assert property (rsp_valid_ff |-> !pci_dac_ff)
        else $error("Dual address cycle raised");

    COV_PCI_IO: cover property (def_req ##1 rsp_cs_ff[RAD_TGT_PCI_IO]);
    COV_BOOT_B: cover property (def_req && boot_bank_swap_select ##1
        rsp_tgt_ff == RAD_TGT_FLASH_B);
    COV_PROG_HIT: cover property (prog_active && take_hit);
    COV_MISS: cover property (rsp_miss_ff);

endmodule : rad_top

// ---- bench/rad_cpu_model.sv ----
/*
 * Processor requester model: one decode request per access call.
 * Assumes the caller waits for reset release before the first access.
 */
`timescale 1ns/100ps
module rad_cpu_model (
    input wire logic sys_clk, // System clock
    output logic req_valid, // Access request
    output logic [rad_pkg::AW-1:0] req_addr, // Access address
    output logic req_write // Write flag
);
    import rad_pkg::*;
    ////////////////////////////////////////////////////////////////////
    // Bus idle at time zero
    initial begin
        req_valid = 1'b0;
        req_addr = 32'h0;
        req_write = 1'b0;
    end
    // Launch just after an edge; calls chain back to back, 32-bit address only
    task automatic access(input logic [AW-1:0] addr, input logic wr);
        @(posedge sys_clk);
        #1;
        req_valid = 1'b1;
        req_addr = addr;
        req_write = wr;
    endtask : access
    // Released lines flip so a stale address never passes for a live one
    task automatic release_bus();
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
        req_addr = ~req_addr;
        req_write = ~req_write;
    endtask : release_bus
endmodule : rad_cpu_model

// ---- bench/testbench.sv ----
/*
 * Self-checking bench for the reset address decoder: a reference model
 * predicts every decode, window write result and mode flag.
 * Assumes the requester model drives the processor side.
 */
`timescale 1ns/100ps
module testbench;
    import rad_pkg::*;
    typedef struct packed {logic [2:0] tgt; logic [31:0] ofs; logic wr;} rad_exp_t;
    logic sys_clk, rstn, req_valid, req_write, boot_bank_swap_select;
    logic map_wr_en, map_wr_enable, map_commit, map_revert;
    logic pci_slave_dec_wr, pci_slave_dec_on, pci_slave_dec_en_ff, pci_dac_ff;
    logic [1:0] map_wr_idx;
    logic [31:0] req_addr, map_wr_lo, map_wr_hi, rsp_ofs_ff;
    rad_tgt_t map_wr_tgt, rsp_tgt_ff;
    logic rsp_valid_ff, rsp_write_ff, rsp_miss_ff, map_prog_mode_ff, map_wr_err_ff;
    logic [7:0] rsp_cs_ff;
    integer seed = 32'h4eb5;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    ////////////////////////////////////////////////////////////////////
    // Reference model: default windows written out independently of the design
    localparam logic [31:0] DW_LO [4] = '{32'h8000_0000, 32'hfef8_0000,
        32'hfeff_0000, 32'hfff0_0000};
    localparam logic [31:0] DW_HI [4] = '{32'h8080_ffff, 32'hfef8_ffff,
        32'hfeff_ffff, 32'hffff_ffff};
    localparam logic [2:0] DW_TGT [4] = '{3'h1, 3'h2, 3'h3, 3'h4};
    logic [31:0] s_lo [4], s_hi [4];
    logic [2:0] s_tgt [4];
    logic s_en [4];
    logic m_mode, m_pci, err_due, legal;
    rad_exp_t exp_q [$];
    rad_exp_t e;
    logic [31:0] probe [18] = '{32'h0, 32'h0fff_ffff, 32'h1000_0000, 32'h7fff_ffff,
        32'h8000_0000, 32'h8080_ffff, 32'h8081_0000, 32'hfef7_ffff, 32'hfef8_0000,
        32'hfef8_ffff, 32'hfef9_0000, 32'hfeff_0000, 32'hfeff_ffff, 32'hff00_0000,
        32'hff8f_ffff, 32'hffef_ffff, 32'hfff0_0000, 32'hffff_ffff};

    rad_top u_rad_top (.sys_clk(sys_clk), .rstn(rstn), .req_valid(req_valid),
        .req_addr(req_addr), .req_write(req_write),
        .boot_bank_swap_select(boot_bank_swap_select), .map_wr_en(map_wr_en),
        .map_wr_idx(map_wr_idx), .map_wr_lo(map_wr_lo), .map_wr_hi(map_wr_hi),
        .map_wr_tgt(map_wr_tgt), .map_wr_enable(map_wr_enable), .map_commit(map_commit),
        .map_revert(map_revert), .pci_slave_dec_wr(pci_slave_dec_wr),
        .pci_slave_dec_on(pci_slave_dec_on), .rsp_valid_ff(rsp_valid_ff),
        .rsp_tgt_ff(rsp_tgt_ff), .rsp_cs_ff(rsp_cs_ff), .rsp_ofs_ff(rsp_ofs_ff),
        .rsp_write_ff(rsp_write_ff), .rsp_miss_ff(rsp_miss_ff),
        .map_prog_mode_ff(map_prog_mode_ff), .map_wr_err_ff(map_wr_err_ff),
        .pci_slave_dec_en_ff(pci_slave_dec_en_ff), .pci_dac_ff(pci_dac_ff));
    rad_cpu_model u_rad_cpu_model (.sys_clk(sys_clk), .req_valid(req_valid),
        .req_addr(req_addr), .req_write(req_write));

    ////////////////////////////////////////////////////////////////////
    // Clock, and a ceiling well above the roughly 430 cycles the run needs
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            mismatches++;
            stop_test();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        if (mismatches == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    // Lowest slot wins, so scan from slot 3 down and let later hits overwrite
    function automatic rad_exp_t model_dec(input logic [31:0] a, input logic b, input logic w);
        rad_exp_t r;
        r = '{tgt: 3'h0, ofs: 32'h0, wr: w};
        for (int i = 3; i >= 0; i--) begin
            if (!m_mode && a >= DW_LO[i] && a <= DW_HI[i]) begin
                r.tgt = (i == 3 && b) ? 3'h5 : DW_TGT[i];
                r.ofs = a - DW_LO[i];
            end
            if (m_mode && s_en[i] && a >= s_lo[i] && a <= s_hi[i]) begin
                r.tgt = s_tgt[i];
                r.ofs = a - s_lo[i];
            end
        end
        return r;
    endfunction : model_dec

    ////////////////////////////////////////////////////////////////////
    // Monitor: outputs read before this edge's updates land, then model steps
    always @(posedge sys_clk) begin
        if (!rstn) begin
            m_mode = 1'b0;
            m_pci = 1'b0;
            err_due = 1'b0;
            exp_q.delete();
            for (int i = 0; i < 4; i++) s_en[i] = 1'b0;
        end else begin
            if (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                chk("rsp_valid", 32'h1, rsp_valid_ff);
                chk("rsp_tgt", e.tgt, rsp_tgt_ff);
                chk("rsp_cs", e.tgt == 0 ? 32'h0 : 32'h1 << e.tgt, rsp_cs_ff);
                chk("rsp_ofs", e.ofs, rsp_ofs_ff);
                chk("rsp_write", e.wr, rsp_write_ff);
                chk("rsp_miss", e.tgt == 0, rsp_miss_ff);
            end else begin
                chk("rsp_valid", 32'h0, rsp_valid_ff);
                chk("rsp_cs", 32'h0, rsp_cs_ff);
            end
            chk("map_wr_err", err_due, map_wr_err_ff);
            chk("prog_mode", m_mode, map_prog_mode_ff);
            chk("pci_slave_en", m_pci, pci_slave_dec_en_ff);
            chk("pci_dac", 32'h0, pci_dac_ff);
            err_due = 1'b0;
            if (req_valid) exp_q.push_back(model_dec(req_addr, boot_bank_swap_select, req_write));
            legal = map_wr_lo <= map_wr_hi
                && !(map_wr_tgt inside {RAD_TGT_FLASH_A, RAD_TGT_FLASH_B}
                && map_wr_hi - map_wr_lo > 32'h00ff_ffff)
                && !(map_wr_tgt == RAD_TGT_DRAM && map_wr_hi > 32'h7fff_ffff);
            if (map_wr_en && !legal) err_due = 1'b1;
            if (map_wr_en && legal) begin
                s_lo[map_wr_idx] = map_wr_lo;
                s_hi[map_wr_idx] = map_wr_hi;
                s_tgt[map_wr_idx] = map_wr_tgt;
                s_en[map_wr_idx] = map_wr_enable;
            end
            // Commit only counts in the default map, revert only in the programmed one
            if (map_commit && !m_mode) m_mode = 1'b1;
            else if (map_revert && m_mode) m_mode = 1'b0;
            if (pci_slave_dec_wr) m_pci = pci_slave_dec_on;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Stimulus tasks; every change lands 1 ns after an edge
    task automatic sweep(input logic b);
        boot_bank_swap_select = b;
        foreach (probe[i]) u_rad_cpu_model.access(probe[i], probe[i][3]);
        u_rad_cpu_model.release_bus();
    endtask : sweep

    // Random addresses, three quarters steered into the 1MB blocks at 808, FEF and FFF
    task automatic rand_run(input int n);
        logic [31:0] a;
        a = $random(seed);
        boot_bank_swap_select = a[5];
        repeat (n) begin
            a = $random(seed);
            if (a[1:0] == 2'h1) a[31:20] = 12'h808;
            if (a[1:0] == 2'h2) a[31:20] = 12'hfef;
            if (a[1:0] == 2'h3) a[31:20] = 12'hfff;
            u_rad_cpu_model.access(a, a[2]);
        end
        u_rad_cpu_model.release_bus();
    endtask : rand_run

    task automatic wr_win(input logic [1:0] idx, input logic [31:0] lo, input logic [31:0] hi,
        input rad_tgt_t tgt, input logic en);
        @(posedge sys_clk);
        #1;
        map_wr_en = 1'b1;
        {map_wr_idx, map_wr_lo, map_wr_hi, map_wr_enable} = {idx, lo, hi, en};
        map_wr_tgt = tgt;
        @(posedge sys_clk);
        #1;
        map_wr_en = 1'b0;
    endtask : wr_win

    // One pulse on commit, revert or the PCI slave enable write
    task automatic ctl(input logic c, input logic r, input logic p, input logic on);
        @(posedge sys_clk);
        #1;
        {map_commit, map_revert, pci_slave_dec_wr, pci_slave_dec_on} = {c, r, p, on};
        @(posedge sys_clk);
        #1;
        {map_commit, map_revert, pci_slave_dec_wr} = 3'h0;
    endtask : ctl

    initial begin
        {rstn, boot_bank_swap_select, map_wr_en, map_wr_idx, map_wr_enable} = 6'h0;
        {map_wr_lo, map_wr_hi} = {32'h0, 32'h0};
        map_wr_tgt = RAD_TGT_NONE;
        {map_commit, map_revert, pci_slave_dec_wr, pci_slave_dec_on} = 4'h0;
        repeat (6) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        sweep(1'b0);
        sweep(1'b1);
        rand_run(150);
        wr_win(2'h0, 32'h0, 32'h0fff_ffff, RAD_TGT_DRAM, 1'b1);
        wr_win(2'h1, 32'h1000_0000, 32'hf3ff_ffff, RAD_TGT_PCI_MEM, 1'b1);
        wr_win(2'h2, 32'hff00_0000, 32'hff7f_ffff, RAD_TGT_FLASH_A, 1'b1);
        wr_win(2'h3, 32'hff80_0000, 32'hff8f_ffff, RAD_TGT_FLASH_B, 1'b1);
        wr_win(2'h3, 32'hfe00_0000, 32'hff00_0000, RAD_TGT_FLASH_B, 1'b1);
        wr_win(2'h0, 32'h0, 32'h8000_0000, RAD_TGT_DRAM, 1'b1);
        wr_win(2'h1, 32'h2000_0000, 32'h1fff_ffff, RAD_TGT_PCI_MEM, 1'b1);
        sweep(1'b0);
        ctl(1'b1, 1'b0, 1'b0, 1'b0);
        sweep(1'b0);
        rand_run(100);
        wr_win(2'h3, 32'hff80_0000, 32'hff8f_ffff, RAD_TGT_FLASH_B, 1'b0);
        sweep(1'b1);
        ctl(1'b0, 1'b0, 1'b1, 1'b1);
        ctl(1'b0, 1'b1, 1'b1, 1'b0);
        sweep(1'b1);
        ctl(1'b1, 1'b0, 1'b1, 1'b1);
        rstn = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        rstn = 1'b1;
        repeat (3) @(posedge sys_clk);
        #1;
        sweep(1'b0);
        // Let the last decode reach the monitor before the verdict
        repeat (2) @(posedge sys_clk);
        #1;
        stop_test();
    end
endmodule : testbench
